/* src/mvcap_regs.v */
`timescale 1ns/10ps
`default_nettype none
`include "mvcap_defines.vh"

// Functional notes
// RULE1: with message enable clear, no message writes are issued.
// RULE2: with message enable set, only message writes; legacy pin held inactive.
// RULE3: wide-address-capable bit reads one from reset.
// RULE4: message address bits 31:2 writable, low two bits read zero.
// RULE5: upper address forms high half of message write address; resets zero.
// RULE6: each request becomes one memory write of programmed address and data; code holds one pending request, further ones merge into it.
// RULE7: message capability header lowest byte reads 05h.
// RULE8: message capability pointer byte reads A4h.
// RULE9: product-data capability lowest byte reads 03h.
// RULE10: product-data pointer byte reads A4h.
// RULE11: software sets 6-bit word address; device uses it for EEPROM cycle.
// RULE12: writing flag zero starts read; flag stays zero, sets on finish.
// RULE13: writing flag one starts write; flag stays one, clears on finish.
// RULE14: software polls flag for change before next access or data read.
// RULE15: data register read returns last word fetched from EEPROM.
// RULE16: data register write supplies word for next EEPROM write; code ignores data register writes made while a cycle is busy.
// RULE17: vendor capability lowest byte reads 09h.
// RULE18: vendor pointer byte reads C4h, the reset value.
// RULE19: vendor length field reads 000Ch.
module mvcap_regs (
  // clock and reset
  input  wire        core_clk_i,
  input  wire        rst_n_i,
  // register port
  input  wire [7:0]  reg_addr_i,
  input  wire [31:0] reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [31:0] reg_rdata_o,
  // service request from function logic
  input  wire        svc_req_i,
  // message write request
  output reg         msg_wr_valid_o,
  output reg  [63:0] msg_wr_addr_o,
  output reg  [15:0] msg_wr_data_o,
  output reg         msg_wr_wide_o,
  input  wire        msg_wr_ready_i,
  // legacy interrupt pin, active low
  output reg         intx_n_o,
  // eeprom table port
  output reg         ee_req_o,
  output reg         ee_we_o,
  output reg  [5:0]  ee_addr_o,
  output reg  [31:0] ee_wdata_o,
  input  wire        ee_done_i,
  input  wire [31:0] ee_rdata_i,
  // interrupt
  output reg         irq_o
);

  // ========================================================
  // register state
  reg        msi_en_reg;
  reg [2:0]  mme_reg;
  reg [29:0] addr_lo_reg;
  reg [31:0] addr_hi_reg;
  reg [15:0] payload_reg;
  reg [5:0]  pd_addr_reg;
  reg        pd_dir_reg;
  reg        pd_busy_reg;
  reg [31:0] pd_rd_reg;
  reg [31:0] pd_wr_reg;
  reg [1:0]  irq_stat_reg;
  reg [1:0]  irq_mask_reg;
  reg        svc_pend_reg;

  wire       wide_cap = `MVCAP_WIDE_RST; // see RULE3

  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  wire wr_ctrl  = reg_wr_i & hit(reg_addr_i, `MVCAP_OFS_MSI_CTRL);
  wire wr_lo    = reg_wr_i & hit(reg_addr_i, `MVCAP_OFS_MSI_ADDR_LO);
  wire wr_hi    = reg_wr_i & hit(reg_addr_i, `MVCAP_OFS_MSI_ADDR_HI);
  wire wr_pay   = reg_wr_i & hit(reg_addr_i, `MVCAP_OFS_MSI_PAYLOAD);
  wire wr_pd    = reg_wr_i & hit(reg_addr_i, `MVCAP_OFS_PD_CTRL);
  wire wr_win   = reg_wr_i & hit(reg_addr_i, `MVCAP_OFS_PD_WINDOW);
  wire wr_stat  = reg_wr_i & hit(reg_addr_i, `MVCAP_OFS_IRQ_STATUS);
  wire wr_mask  = reg_wr_i & hit(reg_addr_i, `MVCAP_OFS_IRQ_MASK);

  // a new cycle is only taken while idle; writes while busy are dropped
  wire pd_start = wr_pd & ~pd_busy_reg;
  wire pd_fin   = pd_busy_reg & ee_done_i;
  wire msg_acc  = msg_wr_valid_o & msg_wr_ready_i;

  // one event line per status bit, in status bit order
  wire [1:0] irq_evt = {msg_acc, pd_fin};

  // ========================================================
  // message capability registers
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      msi_en_reg  <= 1'b0;
      mme_reg     <= 3'h0;
      addr_lo_reg <= 30'h00000000;
      addr_hi_reg <= `MVCAP_ADDR_RST;
      payload_reg <= `MVCAP_PAYLOAD_RST;
    end else begin
      if (wr_ctrl) begin
        msi_en_reg <= reg_wdata_i[`MVCAP_MSI_EN_BIT];
        mme_reg    <= reg_wdata_i[`MVCAP_MME_MSB:`MVCAP_MME_LSB];
      end
      if (wr_lo)
        addr_lo_reg <= reg_wdata_i[31:2]; // see RULE4
      if (wr_hi)
        addr_hi_reg <= reg_wdata_i; // see RULE5
      if (wr_pay)
        payload_reg <= reg_wdata_i[15:0];
    end
  end

  // ========================================================
  // message write issue and legacy pin
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      svc_pend_reg   <= 1'b0;
      msg_wr_valid_o <= 1'b0;
      msg_wr_addr_o  <= 64'h0000000000000000;
      msg_wr_data_o  <= 16'h0000;
      msg_wr_wide_o  <= 1'b0;
      intx_n_o       <= 1'b1;
    end else begin
      // a request arriving while one is outstanding is held once more
      if (svc_req_i & msi_en_reg & msg_wr_valid_o & ~msg_acc)
        svc_pend_reg <= 1'b1;
      else if (~msg_wr_valid_o | msg_acc)
        svc_pend_reg <= 1'b0;
      if (msg_acc)
        msg_wr_valid_o <= 1'b0;
      if (msi_en_reg & (svc_req_i | svc_pend_reg) &
          (~msg_wr_valid_o | msg_acc)) begin // see RULE1
        msg_wr_valid_o <= 1'b1; // see RULE6
        msg_wr_addr_o  <= {(wide_cap ? addr_hi_reg : 32'h00000000),
                           addr_lo_reg, 2'b00}; // see RULE5
        msg_wr_data_o  <= payload_reg; // see RULE6
        msg_wr_wide_o  <= wide_cap & (addr_hi_reg != 32'h00000000);
      end
      // legacy pin follows the request only while messages are off
      intx_n_o <= ~(svc_req_i & ~msi_en_reg); // see RULE2
    end
  end

  // ========================================================
  // product-data address/flag and eeprom cycle
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pd_addr_reg <= `MVCAP_PD_ADDR_RST;
      pd_dir_reg  <= `MVCAP_PD_DIR_RST;
      pd_busy_reg <= 1'b0;
      pd_rd_reg   <= 32'h00000000;
      pd_wr_reg   <= 32'h00000000;
      ee_req_o    <= 1'b0;
      ee_we_o     <= 1'b0;
      ee_addr_o   <= 6'h00;
      ee_wdata_o  <= 32'h00000000;
    end else begin
      if (wr_win & ~pd_busy_reg)
        pd_wr_reg <= reg_wdata_i; // see RULE16
      if (pd_start) begin
        pd_addr_reg <= reg_wdata_i[`MVCAP_PD_ADDR_MSB:`MVCAP_PD_ADDR_LSB];
        pd_dir_reg  <= reg_wdata_i[`MVCAP_PD_DIR_BIT]; // see RULE12
        pd_busy_reg <= 1'b1;
        ee_req_o    <= 1'b1;
        ee_we_o     <= reg_wdata_i[`MVCAP_PD_DIR_BIT]; // see RULE13
        ee_addr_o   <= reg_wdata_i[`MVCAP_PD_ADDR_MSB:`MVCAP_PD_ADDR_LSB];
        ee_wdata_o  <= pd_wr_reg; // see RULE16
      end else if (pd_fin) begin
        pd_busy_reg <= 1'b0;
        ee_req_o    <= 1'b0;
        pd_dir_reg  <= ~pd_dir_reg; // see RULE12 see RULE13
        if (~pd_dir_reg)
          pd_rd_reg <= ee_rdata_i; // see RULE15
      end
    end
  end

  // ========================================================
  // interrupt status bits, one sticky flop each
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_stat
      always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          irq_stat_reg[g] <= 1'b0;
        end else if (irq_evt[g]) begin
          // set wins over a write-one clear in the same cycle
          irq_stat_reg[g] <= 1'b1;
        end else if (wr_stat & reg_wdata_i[g]) begin
          irq_stat_reg[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // ========================================================
  // interrupt mask and level output
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_mask_reg <= 2'b00;
      irq_o        <= 1'b0;
    end else begin
      if (wr_mask)
        irq_mask_reg <= reg_wdata_i[1:0];
      irq_o <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ========================================================
  // read path
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `MVCAP_OFS_MSI_CTRL:
          reg_rdata_o <= {8'h00, wide_cap, mme_reg, 3'b000, msi_en_reg,
                          `MVCAP_MSI_NEXT_PTR, `MVCAP_MSI_CAP_ID};
                          // see RULE7 see RULE8 see RULE3
        `MVCAP_OFS_MSI_ADDR_LO:
          reg_rdata_o <= {addr_lo_reg, 2'b00}; // see RULE4
        `MVCAP_OFS_MSI_ADDR_HI:
          reg_rdata_o <= addr_hi_reg;
        `MVCAP_OFS_MSI_PAYLOAD:
          reg_rdata_o <= {16'h0000, payload_reg};
        `MVCAP_OFS_PD_CTRL:
          reg_rdata_o <= {pd_dir_reg, 7'h00, pd_addr_reg, 2'b00,
                          `MVCAP_PD_NEXT_PTR, `MVCAP_PD_CAP_ID};
                          // see RULE9 see RULE10
        `MVCAP_OFS_PD_WINDOW:
          reg_rdata_o <= pd_rd_reg; // see RULE15
        `MVCAP_OFS_VEND_HDR:
          reg_rdata_o <= {`MVCAP_VEND_LENGTH, `MVCAP_VEND_NEXT_PTR,
                          `MVCAP_VEND_CAP_ID};
                          // see RULE17 see RULE18 see RULE19
        `MVCAP_OFS_IRQ_STATUS:
          reg_rdata_o <= {30'h00000000, irq_stat_reg};
        `MVCAP_OFS_IRQ_MASK:
          reg_rdata_o <= {30'h00000000, irq_mask_reg};
        default:
          reg_rdata_o <= 32'h00000000;
      endcase
    end else begin
      reg_rdata_o <= 32'h00000000;
    end
  end

endmodule // mvcap_regs
`default_nettype wire

/* src/mvcap_defines.vh */
`ifndef MVCAP_DEFINES_VH
`define MVCAP_DEFINES_VH
// ==========================================================
// register byte offsets
`define MVCAP_OFS_MSI_CTRL      8'h8c
`define MVCAP_OFS_MSI_ADDR_LO   8'h90
`define MVCAP_OFS_MSI_ADDR_HI   8'h94
`define MVCAP_OFS_MSI_PAYLOAD   8'h98
`define MVCAP_OFS_PD_CTRL       8'h9c
`define MVCAP_OFS_PD_WINDOW     8'ha0
`define MVCAP_OFS_VEND_HDR      8'ha4
`define MVCAP_OFS_IRQ_STATUS    8'hf0
`define MVCAP_OFS_IRQ_MASK      8'hf4
// ==========================================================
// capability header constants
`define MVCAP_MSI_CAP_ID        8'h05
`define MVCAP_MSI_NEXT_PTR      8'ha4
`define MVCAP_PD_CAP_ID         8'h03
`define MVCAP_PD_NEXT_PTR       8'ha4
`define MVCAP_VEND_CAP_ID       8'h09
`define MVCAP_VEND_NEXT_PTR     8'hc4
`define MVCAP_VEND_LENGTH       16'h000c
// ==========================================================
// field positions
`define MVCAP_MSI_EN_BIT        16
`define MVCAP_MME_LSB           20
`define MVCAP_MME_MSB           22
`define MVCAP_WIDE_BIT          23
`define MVCAP_PD_ADDR_LSB       18
`define MVCAP_PD_ADDR_MSB       23
`define MVCAP_PD_DIR_BIT        31
// ==========================================================
// reset values
`define MVCAP_WIDE_RST          1'b1
`define MVCAP_ADDR_RST          32'h00000000
`define MVCAP_PAYLOAD_RST       16'h0000
`define MVCAP_PD_ADDR_RST       6'h00
`define MVCAP_PD_DIR_RST        1'b0
// ==========================================================
// interrupt status bits
`define MVCAP_IRQ_PD_DONE       0
`define MVCAP_IRQ_MSI_SENT      1
`endif

/* verification/mvcap_regs_props.sv */
`timescale 1ns/10ps
`default_nettype none
module mvcap_regs_props (
  // clock and reset
  input wire logic        core_clk_i, rst_n_i,
  // register port
  input wire logic [7:0]  reg_addr_i,
  input wire logic [31:0] reg_wdata_i, reg_rdata_o,
  input wire logic        reg_wr_i, reg_rd_i,
  // messages and legacy pin
  input wire logic        svc_req_i, msg_wr_valid_o, msg_wr_ready_i,
  input wire logic [63:0] msg_wr_addr_o,
  input wire logic [15:0] msg_wr_data_o,
  input wire logic        intx_n_o,
  // eeprom
  input wire logic        ee_req_o, ee_we_o, ee_done_i,
  input wire logic [5:0]  ee_addr_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ====================
  // enable shadow, tracked from register writes
  logic en_reg;
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) en_reg <= 1'b0;
    else if (reg_wr_i && reg_addr_i == 8'h8c) en_reg <= reg_wdata_i[16];
  end
  a_no_msg_off: assert property (!en_reg && !msg_wr_valid_o |=> !msg_wr_valid_o) else $error("message write while disabled");
  a_intx_quiet: assert property (en_reg && $past(en_reg) |-> intx_n_o) else $error("legacy pin used while enabled");
  a_intx_legacy: assert property (!en_reg && svc_req_i |=> !intx_n_o) else $error("legacy pin not asserted");
  a_msg_issue: assert property (en_reg && svc_req_i && !msg_wr_valid_o |=> msg_wr_valid_o) else $error("no message write issued");
  a_msg_hold: assert property (msg_wr_valid_o && !msg_wr_ready_i |=> msg_wr_valid_o && $stable(msg_wr_addr_o) && $stable(msg_wr_data_o)) else $error("message dropped or changed");
  a_addr_align: assert property (msg_wr_valid_o |-> msg_wr_addr_o[1:0] == 2'b00) else $error("unaligned message address");
  a_msi_hdr: assert property (reg_rd_i && reg_addr_i == 8'h8c |=> reg_rdata_o[15:0] == 16'ha405 && reg_rdata_o[23]) else $error("bad message header");
  a_pd_hdr: assert property (reg_rd_i && reg_addr_i == 8'h9c |=> reg_rdata_o[15:0] == 16'ha403) else $error("bad product data header");
  a_vend_hdr: assert property (reg_rd_i && reg_addr_i == 8'ha4 |=> reg_rdata_o == 32'h000cc409) else $error("bad vendor header");
  a_ee_start: assert property (reg_wr_i && reg_addr_i == 8'h9c && !ee_req_o |=> ee_req_o && ee_we_o == $past(reg_wdata_i[31]) && ee_addr_o == $past(reg_wdata_i[23:18])) else $error("eeprom cycle not started");
  a_ee_end: assert property (ee_req_o && ee_done_i |=> !ee_req_o) else $error("eeprom cycle not ended");
  c_msg: cover property (msg_wr_valid_o && msg_wr_ready_i);
  c_ee_rd: cover property (ee_done_i && ee_req_o && !ee_we_o);
  c_ee_wr: cover property (ee_done_i && ee_req_o && ee_we_o);
endmodule // mvcap_regs_props
`default_nettype wire

/* verification/mvcap_far_model.sv */
`timescale 1ns/10ps
`default_nettype none
module mvcap_far_model (
  // clock, reset and pace
  input wire logic        core_clk_i, rst_n_i, slow_i,
  // eeprom side
  input wire logic        ee_req_o, ee_we_o,
  input wire logic [5:0]  ee_addr_o,
  input wire logic [31:0] ee_wdata_o,
  output var logic        ee_done_i,
  output wire logic [31:0] ee_rdata_i,
  // message sink
  input wire logic        msg_wr_valid_o,
  output wire logic       msg_wr_ready_i
);
  logic [31:0] mem [0:63];
  logic [31:0] q;
  logic [2:0]  cnt;
  logic [1:0]  ph;
  logic        lock;
  // data is junk outside the done cycle, so stale reads show up
  assign ee_rdata_i = ee_done_i ? q : ~q;
  // slow sink accepts one cycle in four
  assign msg_wr_ready_i = !slow_i || ph == 2'h3;
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ee_done_i <= 1'b0; lock <= 1'b0; cnt <= 3'h0; ph <= 2'h0; q <= 32'h0;
    end else begin
      ph <= ph + 2'h1;
      ee_done_i <= 1'b0;
      if (!ee_req_o) begin
        lock <= 1'b0; cnt <= 3'h0;
      end else if (!lock && cnt >= (slow_i ? 3'h5 : 3'h0)) begin
        ee_done_i <= 1'b1; lock <= 1'b1;
        if (ee_we_o) mem[ee_addr_o] <= ee_wdata_o;
        else q <= mem[ee_addr_o];
      end else if (!lock) cnt <= cnt + 3'h1;
    end
  end
endmodule // mvcap_far_model
`default_nettype wire

/* verification/mvcap_regs_test.sv */
`timescale 1ns/10ps
`default_nettype none
module mvcap_regs_test;
  logic core_clk_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic svc_req_i = 0, slow_i = 0;
  logic [7:0] reg_addr_i = 8'h0;
  logic [31:0] reg_wdata_i = 32'h0, seed = 32'h5554;
  wire logic [31:0] reg_rdata_o, ee_wdata_o, ee_rdata_i;
  wire logic [63:0] msg_wr_addr_o;
  wire logic [15:0] msg_wr_data_o;
  wire logic [5:0] ee_addr_o;
  wire logic msg_wr_valid_o, msg_wr_wide_o, msg_wr_ready_i, intx_n_o;
  wire logic ee_req_o, ee_we_o, ee_done_i, irq_o;
  int err_count = 0, check_count = 0;
  mvcap_regs u_dut (.*);
  mvcap_far_model u_far (.*);
  initial forever #5 core_clk_i = ~core_clk_i;
  // ====================
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic tick(); @(posedge core_clk_i); #1; endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i) begin reg_wr_i <= 1; reg_addr_i <= a; reg_wdata_i <= d; end
    @(posedge core_clk_i) reg_wr_i <= 0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk_i) begin reg_rd_i <= 1; reg_addr_i <= a; end
    @(posedge core_clk_i) reg_rd_i <= 0;
    #1 d = reg_rdata_o;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v); chk(v, e);
  endtask
  task automatic pulse_req();
    @(posedge core_clk_i) svc_req_i <= 1;
    @(posedge core_clk_i) svc_req_i <= 0;
    #1;
  endtask
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin #200000; err_count++; give_verdict(); end
  // ====================
  // main sequence
  initial begin
    logic [31:0] v, d, lo, hi, pay;
    logic [5:0] k;
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    rchk(8'h8c, 32'h0080a405);
    rchk(8'h9c, 32'h0000a403);
    rchk(8'ha4, 32'h000cc409);
    rchk(8'h94, 32'h0);
    rchk(8'h50, 32'h0);
    pulse_req();
    chk({intx_n_o, msg_wr_valid_o}, 2'b00);
    wr(8'h8c, 32'hffffffff); wr(8'ha4, 32'h0);
    rchk(8'h8c, 32'h00f1a405);
    rchk(8'ha4, 32'h000cc409);
    wr(8'hf4, 32'h3);
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk_i) slow_i <= i[0];
      lo = rnd(); hi = i ? rnd() : 32'h0; pay = rnd();
      wr(8'h90, lo); wr(8'h94, hi); wr(8'h98, pay);
      rchk(8'h90, lo & 32'hfffffffc);
      rchk(8'h98, {16'h0, pay[15:0]});
      pulse_req();
      chk({intx_n_o, msg_wr_valid_o}, 2'b11);
      chk(msg_wr_addr_o, {hi, lo[31:2], 2'b00});
      chk({msg_wr_wide_o, msg_wr_data_o}, {hi != 32'h0, pay[15:0]});
      repeat (20) if (msg_wr_valid_o) tick();
      rchk(8'hf0, 32'h2);
      chk(irq_o, 1'b1);
      wr(8'hf0, 32'h2);
      rchk(8'hf0, 32'h0);
      chk(irq_o, 1'b0);
    end
    wr(8'hf4, 32'h2);
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk_i) slow_i <= i[0];
      v = rnd(); k = v[5:0]; d = rnd();
      wr(8'ha0, d);
      wr(8'h9c, {1'b1, 7'h0, k, 18'h0});
      rd(8'h9c, v);
      if (i) chk(v[31], 1'b1);
      repeat (20) if (v[31]) rd(8'h9c, v);
      chk(v, {8'h0, k, 2'b00, 16'ha403});
      chk(u_far.mem[k], d);
      wr(8'ha0, ~d);
      wr(8'h9c, {8'h0, k, 18'h0});
      rd(8'h9c, v);
      if (i) chk(v[31], 1'b0);
      repeat (20) if (!v[31]) rd(8'h9c, v);
      chk(v[31], 1'b1);
      rchk(8'ha0, d);
    end
    rchk(8'hf0, 32'h1);
    chk(irq_o, 1'b0);
    wr(8'hf4, 32'h1); tick(); tick();
    chk(irq_o, 1'b1);
    wr(8'hf0, 32'h1); tick(); tick();
    chk(irq_o, 1'b0);
    give_verdict();
  end
endmodule // mvcap_regs_test
bind mvcap_regs mvcap_regs_props u_props (.*);
`default_nettype wire
